// *** hdl/csp_regs.svh ***
// object indices, reset values, field positions and loop constants
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// object dictionary indices
`define CSP_IDX_CTRL      16'h6040
`define CSP_IDX_STAT      16'h6041
`define CSP_IDX_MODE      16'h6060
`define CSP_IDX_POS_ACT   16'h6064
`define CSP_IDX_LAG_WIN   16'h6065
`define CSP_IDX_VEL_ACT   16'h606C
`define CSP_IDX_FRC_LIM   16'h6072
`define CSP_IDX_FRC_ACT   16'h6077
`define CSP_IDX_POS_TGT   16'h607A
`define CSP_IDX_POS_OFS   16'h60B0
`define CSP_IDX_VEL_OFS   16'h60B1
`define CSP_IDX_FRC_OFS   16'h60B2
`define CSP_IDX_LAG_ACT   16'h60F4

// reset values
`define CSP_CTRL_RST      16'h0000
`define CSP_MODE_RST      8'h00
`define CSP_LAG_WIN_RST   32'h000186A0
`define CSP_FRC_LIM_RST   16'h1388

// lag window limits
`define CSP_LAG_WIN_MAX   32'h08000000
`define CSP_LAG_WIN_OFF   32'hFFFFFFFF
`define CSP_LAG_WIN_ZERO  32'h00000000

// mode code for cyclic synchronous position
`define CSP_MODE_CSP      8'h08

// control word bits
`define CSP_CW_ENABLE     3
`define CSP_CW_FLT_RST    7

// status word bits
`define CSP_SW_ENABLED    2
`define CSP_SW_STALE      10
`define CSP_SW_LAG_ERR    13

// loop gains as right shifts
`define CSP_KP_SHIFT      4
`define CSP_KV_SHIFT      4

// target fifo shape
`define CSP_FIFO_W        32
`define CSP_FIFO_D        16

`endif

// *** hdl/csp_pkg.sv ***
// shared types for the cyclic position block
package csp_pkg;

  // control sequence run once per sync pulse
  typedef enum logic [4:0] {
    CSP_ST_IDLE  = 5'b00001,
    CSP_ST_SAMP  = 5'b00010,
    CSP_ST_LAG   = 5'b00100,
    CSP_ST_SPEED = 5'b01000,
    CSP_ST_FORCE = 5'b10000
  } csp_state_t;

  // object access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [31:0] wdata;
  } csp_obj_req_t;

  // object access answer
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } csp_obj_rsp_t;

  // power stage command
  typedef struct packed {
    logic        en;
    logic [15:0] frc;
    logic        lag_fault;
  } csp_drv_t;

endpackage

// *** hdl/csp_top.sv ***
// cyclic synchronous position objects, control loops and lag supervision
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
`include "csp_regs.svh"

// ****************************************************************
// target fifo
// ****************************************************************
module csp_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output      logic         in_ready,
  // drain side
  output      logic         out_valid,
  output      logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
  } csp_fifo_state_t;

  csp_fifo_state_t r;
  csp_fifo_state_t n;
  logic            push;
  logic            pop;

  // ready is a flop so the port needs no logic behind it
  assign in_ready  = r.rdy;
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign push      = in_valid & r.rdy;
  assign pop       = out_ready & (r.cnt != '0);

  // pointer and count update
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    n.rdy = (n.cnt < (AW+1)'(D));
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r     <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end
endmodule

// ****************************************************************
// top level
// ****************************************************************
module csp_top (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // object access port
  input  wire csp_pkg::csp_obj_req_t obj_req,
  output      csp_pkg::csp_obj_rsp_t obj_rsp,
  output      logic                 tgt_ready,
  // network timing and feedback pins
  input  wire logic                 periodic_sync_pulse,
  input  wire logic [31:0]          enc_position,
  input  wire logic [15:0]          frc_sense,
  // power stage
  output      csp_pkg::csp_drv_t    drv
);
  import csp_pkg::*;

  typedef struct packed {
    logic [15:0]  ctrl;
    logic [7:0]   mode;
    logic [31:0]  win;
    logic [15:0]  flim;
    logic [31:0]  pofs;
    logic [31:0]  vofs;
    logic [15:0]  fofs;
    logic [31:0]  tgt;
    logic [31:0]  pos_act;
    logic [31:0]  vel_act;
    logic [15:0]  frc_act;
    logic [31:0]  lag;
    logic [31:0]  vcmd;
    logic         lag_flt;
    logic         stale;
    csp_state_t   st;
    logic         sync_s1;
    logic         sync_s2;
    logic         sync_s3;
    logic [31:0]  pos_s1;
    logic [31:0]  pos_s2;
    logic [15:0]  frc_s1;
    logic [15:0]  frc_s2;
    csp_obj_rsp_t rsp;
    csp_drv_t     drv;
  } csp_top_state_t;

  csp_top_state_t r;
  csp_top_state_t n;

  logic        tgt_push;
  logic        fifo_rdy;
  logic        fifo_vld;
  logic [31:0] fifo_data;
  logic        fifo_pop;
  logic        run;

  // a target write is a stream word; a full fifo refuses it
  assign tgt_push = obj_req.wr & (obj_req.index == `CSP_IDX_POS_TGT);
  assign fifo_pop = (r.st == CSP_ST_SAMP);
  assign run      = (r.mode == `CSP_MODE_CSP) & r.ctrl[`CSP_CW_ENABLE];

  assign obj_rsp   = r.rsp;
  assign drv       = r.drv;
  assign tgt_ready = fifo_rdy;

  csp_fifo #(
    .W (`CSP_FIFO_W),
    .D (`CSP_FIFO_D)
  ) u_tgt_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (tgt_push),
    .in_data   (obj_req.wdata),
    .in_ready  (fifo_rdy),
    .out_valid (fifo_vld),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic signed [32:0] dv;
    logic signed [33:0] fsum;
    logic signed [33:0] flim_s;
    logic [32:0]        mag;
    logic               hit;
    n      = r;
    dv     = $signed({r.vcmd[31], r.vcmd}) - $signed({r.vel_act[31], r.vel_act});
    fsum   = ($signed({dv[32], dv}) >>> `CSP_KV_SHIFT)
             + $signed({{18{r.fofs[15]}}, r.fofs});
    flim_s = $signed({18'h00000, r.flim});
    mag    = r.lag[31] ? (~{1'b1, r.lag} + 33'h000000001) : {1'b0, r.lag};
    // zero window always trips; the all-ones value never does
    hit    = (r.win == `CSP_LAG_WIN_ZERO)
             | ((r.win != `CSP_LAG_WIN_OFF)
                & (mag > {1'b0, r.win}));

    // pin synchronisers; the second stage feeds logic, and sync_s3 also feeds the pulse edge detect
    // the encoder word is not gray coded, so it must hold still near a pulse
    n.sync_s1 = periodic_sync_pulse;
    n.sync_s2 = r.sync_s1;
    n.sync_s3 = r.sync_s2;
    n.pos_s1  = enc_position;
    n.pos_s2  = r.pos_s1;
    n.frc_s1  = frc_sense;
    n.frc_s2  = r.frc_s1;

    // object writes and reads
    n.rsp.valid = obj_req.wr | obj_req.rd;
    n.rsp.err   = 1'b0;
    n.rsp.rdata = 32'h00000000;
    if (obj_req.wr) begin
      case (obj_req.index)
        `CSP_IDX_CTRL:    n.ctrl = obj_req.wdata[15:0];
        `CSP_IDX_MODE:    n.mode = obj_req.wdata[7:0];
        `CSP_IDX_LAG_WIN: begin
          // out of range values clamp, so the read back shows the clamp
          if (obj_req.wdata == `CSP_LAG_WIN_OFF) begin
            n.win = obj_req.wdata;
          end else if (obj_req.wdata > `CSP_LAG_WIN_MAX) begin
            n.win = `CSP_LAG_WIN_MAX;
          end else begin
            n.win = obj_req.wdata;
          end
        end
        `CSP_IDX_FRC_LIM: n.flim = obj_req.wdata[15:0];
        `CSP_IDX_POS_TGT: n.rsp.err = ~fifo_rdy;
        `CSP_IDX_POS_OFS: n.pofs = obj_req.wdata;
        `CSP_IDX_VEL_OFS: n.vofs = obj_req.wdata;
        `CSP_IDX_FRC_OFS: n.fofs = obj_req.wdata[15:0];
        default:          n.rsp.err = 1'b1;   // read-only or absent
      endcase
    end else if (obj_req.rd) begin
      case (obj_req.index)
        `CSP_IDX_CTRL:    n.rsp.rdata = {16'h0000, r.ctrl};
        `CSP_IDX_STAT: begin
          n.rsp.rdata[`CSP_SW_ENABLED] = run;
          n.rsp.rdata[`CSP_SW_STALE]   = r.stale;
          n.rsp.rdata[`CSP_SW_LAG_ERR] = r.lag_flt;
        end
        `CSP_IDX_MODE:    n.rsp.rdata = {24'h000000, r.mode};
        `CSP_IDX_POS_ACT: n.rsp.rdata = r.pos_act;
        `CSP_IDX_LAG_WIN: n.rsp.rdata = r.win;
        `CSP_IDX_VEL_ACT: n.rsp.rdata = r.vel_act;
        `CSP_IDX_FRC_LIM: n.rsp.rdata = {16'h0000, r.flim};
        `CSP_IDX_FRC_ACT: n.rsp.rdata = {16'h0000, r.frc_act};
        `CSP_IDX_POS_TGT: n.rsp.rdata = r.tgt;
        `CSP_IDX_POS_OFS: n.rsp.rdata = r.pofs;
        `CSP_IDX_VEL_OFS: n.rsp.rdata = r.vofs;
        `CSP_IDX_FRC_OFS: n.rsp.rdata = {16'h0000, r.fofs};
        `CSP_IDX_LAG_ACT: n.rsp.rdata = r.lag;
        default:          n.rsp.err   = 1'b1;
      endcase
    end

    // fault reset clears sticky flags; a same-cycle event below wins
    if (obj_req.wr & (obj_req.index == `CSP_IDX_CTRL)
        & obj_req.wdata[`CSP_CW_FLT_RST]) begin
      n.lag_flt = 1'b0;
      n.stale   = 1'b0;
    end

    // control sequence, one pass per sync pulse
    unique case (r.st)
      CSP_ST_IDLE: begin
        if (r.sync_s2 & ~r.sync_s3) begin
          n.st = CSP_ST_SAMP;
        end
      end
      CSP_ST_SAMP: begin
        // a missing target keeps the last one and is flagged
        if (fifo_vld) begin
          n.tgt = fifo_data;
        end else begin
          n.stale = 1'b1;
        end
        n.vel_act = r.pos_s2 - r.pos_act;                 // per sync period
        n.pos_act = r.pos_s2;
        n.frc_act = r.frc_s2;
        n.st      = CSP_ST_LAG;
      end
      CSP_ST_LAG: begin
        n.lag = r.tgt + r.pofs - r.pos_act;
        n.st  = CSP_ST_SPEED;
      end
      CSP_ST_SPEED: begin
        n.vcmd = 32'($signed(r.lag) >>> `CSP_KP_SHIFT) + r.vofs;
        if (hit) begin
          n.lag_flt = 1'b1;
        end
        n.st = CSP_ST_FORCE;
      end
      CSP_ST_FORCE: begin
        // clamp to the force limit before it reaches the power stage
        if (!run) begin
          n.drv.frc = 16'h0000;
        end else if (fsum > flim_s) begin
          n.drv.frc = r.flim;
        end else if (fsum < -flim_s) begin
          n.drv.frc = 16'(-flim_s);
        end else begin
          n.drv.frc = fsum[15:0];
        end
        n.st = CSP_ST_IDLE;
      end
    endcase
    n.drv.en        = run;
    n.drv.lag_fault = n.lag_flt;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r      <= '0;
      r.ctrl <= `CSP_CTRL_RST;
      r.mode <= `CSP_MODE_RST;
      r.win  <= `CSP_LAG_WIN_RST;
      r.flim <= `CSP_FRC_LIM_RST;
      r.st   <= CSP_ST_IDLE;
    end else begin
      r <= n;
    end
  end
endmodule

// *** dv/csp_properties.sv ***
// port checks for the cyclic position block
`timescale 1ns/100ps
`include "csp_regs.svh"
module csp_chk (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  srst,
  // object port and pins
  input wire csp_pkg::csp_obj_req_t obj_req,
  input wire csp_pkg::csp_obj_rsp_t obj_rsp,
  input wire logic                  tgt_ready,
  input wire logic                  periodic_sync_pulse,
  input wire csp_pkg::csp_drv_t     drv
);
  import csp_pkg::*;
  logic [3:0] idle_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // cycles since a sync edge, saturating; 15 is well past the pass latency
  always_ff @(posedge core_clk) begin
    if (!srst && $rose(periodic_sync_pulse)) idle_q <= 4'h0;
    else if (srst || idle_q == 4'hF) idle_q <= 4'hF;
    else idle_q <= idle_q + 4'h1;
  end
  property p_answer; obj_req.wr || obj_req.rd |=> obj_rsp.valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  property p_quiet; !(obj_req.wr || obj_req.rd) |=> !obj_rsp.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_win_rd;
    obj_req.rd && !obj_req.wr && obj_req.index == `CSP_IDX_LAG_WIN
      |=> obj_rsp.rdata <= `CSP_LAG_WIN_MAX || obj_rsp.rdata == `CSP_LAG_WIN_OFF;
  endproperty
  a_win_rd: assert property (p_win_rd) else $error("window out of range");
  property p_win_wr; obj_req.wr && obj_req.index == `CSP_IDX_LAG_WIN |=> !obj_rsp.err; endproperty
  a_win_wr: assert property (p_win_wr) else $error("window write refused");
  property p_lag_ro; obj_req.wr && obj_req.index == `CSP_IDX_LAG_ACT |=> obj_rsp.err; endproperty
  a_lag_ro: assert property (p_lag_ro) else $error("lag value written");
  property p_full;
    obj_req.wr && obj_req.index == `CSP_IDX_POS_TGT && !tgt_ready |=> obj_rsp.err;
  endproperty
  a_full: assert property (p_full) else $error("full queue took target");
  property p_frc_hold; idle_q == 4'hF |-> $stable(drv.frc); endproperty
  a_frc_hold: assert property (p_frc_hold) else $error("force moved off pass");
  property p_fault_pass; $rose(drv.lag_fault) |-> idle_q < 4'hF; endproperty
  a_fault_pass: assert property (p_fault_pass) else $error("lag fault off pass");
endmodule
bind csp_top csp_chk u_csp_chk (.core_clk(core_clk), .srst(srst), .obj_req(obj_req),
  .obj_rsp(obj_rsp), .tgt_ready(tgt_ready), .periodic_sync_pulse(periodic_sync_pulse),
  .drv(drv));

// *** dv/csp_host_model.sv ***
// host controller model: object accesses and paced sync periods
`timescale 1ns/100ps
`include "csp_regs.svh"
module csp_host_model #(
  parameter int SYNC_CYC = 2500
) (
  // clock
  input  wire logic                  core_clk,
  // object port and sync pin
  output      csp_pkg::csp_obj_req_t obj_req,
  input  wire csp_pkg::csp_obj_rsp_t obj_rsp,
  output      logic                  periodic_sync_pulse
);
  import csp_pkg::*;
  initial begin
    obj_req = '0;
    periodic_sync_pulse = 1'b0;
  end
  // strobe for one edge; idle lines are inverted so stale values cannot pass
  task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d,
                        output csp_obj_rsp_t r);
    @(posedge core_clk);
    #10;
    obj_req = '{w, !w, i, d};
    @(posedge core_clk);
    #10;
    r = obj_rsp;
    obj_req = '{1'b0, 1'b0, ~i, ~d};
  endtask
  // one 250 us period: fresh target, then the pulse
  task automatic period(input logic push, input logic [31:0] tgt);
    csp_obj_rsp_t r;
    if (push) access(1'b1, `CSP_IDX_POS_TGT, tgt, r);
    // a target access costs two edges, so the pulse spacing stays exact
    repeat (SYNC_CYC - (push ? 32 : 30)) @(posedge core_clk);
    #10;
    periodic_sync_pulse = 1'b1;
    repeat (10) @(posedge core_clk);
    #10;
    periodic_sync_pulse = 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
endmodule

// *** dv/csp_top_tb.sv ***
// self-checking bench for the cyclic position block
`timescale 1ns/100ps
`include "csp_regs.svh"
module csp_top_tb;
  import csp_pkg::*;
  localparam logic [33:0] OK = {2'b10, 32'h0};
  logic         core_clk     = 1'b0;
  logic         srst         = 1'b1;
  logic [31:0]  enc_position = 32'h0;
  logic [15:0]  frc_sense    = 16'h0123;
  csp_obj_req_t obj_req;
  csp_obj_rsp_t obj_rsp;
  logic         tgt_ready;
  logic         periodic_sync_pulse;
  csp_drv_t     drv;
  int           errors       = 0;
  int           checks_done  = 0;
  always #50 core_clk = ~core_clk;
  csp_top u_csp_top (.core_clk(core_clk), .srst(srst), .obj_req(obj_req),
    .obj_rsp(obj_rsp), .tgt_ready(tgt_ready), .periodic_sync_pulse(periodic_sync_pulse),
    .enc_position(enc_position), .frc_sense(frc_sense), .drv(drv));
  csp_host_model u_csp_host_model (.core_clk(core_clk), .obj_req(obj_req),
    .obj_rsp(obj_rsp), .periodic_sync_pulse(periodic_sync_pulse));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one access judged on valid, err and read data together
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
                     input logic [33:0] exp);
    csp_obj_rsp_t r;
    u_csp_host_model.access(w, i, d, r);
    chk({r.valid, r.err, r.rdata}, exp);
  endtask
  task automatic t_reset;
    logic [15:0] ix [13] = '{16'h6040, 16'h6041, 16'h6060, 16'h6064, 16'h6065, 16'h606C,
      16'h6072, 16'h6077, 16'h607A, 16'h60B0, 16'h60B1, 16'h60B2, 16'h60F4};
    for (int k = 0; k < 13; k++) begin
      acc(1'b0, ix[k], 32'h0,
          {2'b10, k == 4 ? 32'h186A0 : k == 6 ? 32'h1388 : 32'h0});
    end
    acc(1'b0, 16'h6000, 32'h0, {2'b11, 32'h0});
    acc(1'b1, `CSP_IDX_POS_ACT, 32'h1, {2'b11, 32'h0});
    acc(1'b1, `CSP_IDX_LAG_ACT, 32'h1, {2'b11, 32'h0});
  endtask
  task automatic t_window;
    logic [31:0] wv [5] = '{32'h0, 32'h08000000, 32'h08000001, 32'hFFFFFFFE, 32'hFFFFFFFF};
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, `CSP_IDX_LAG_WIN, wv[k], OK);
      acc(1'b0, `CSP_IDX_LAG_WIN, 32'h0, {2'b10, wv[k] == 32'hFFFFFFFF ? wv[k] :
        wv[k] > 32'h08000000 ? 32'h08000000 : wv[k]});
    end
  endtask
  // fill the queue until refused, then drain it one pass at a time
  task automatic t_fifo;
    for (int k = 0; k < 16; k++) acc(1'b1, `CSP_IDX_POS_TGT, k, OK);
    chk(tgt_ready, 34'h0);
    acc(1'b1, `CSP_IDX_POS_TGT, 32'h99, {2'b11, 32'h0});
    for (int k = 0; k < 17; k++) u_csp_host_model.period(1'b0, 32'h0);
    chk(tgt_ready, 34'h1);
    acc(1'b0, `CSP_IDX_POS_TGT, 32'h0, {2'b10, 32'hF});
    acc(1'b0, `CSP_IDX_STAT, 32'h0, {2'b10, 32'h0400});
  endtask
  task automatic t_loop;
    acc(1'b1, `CSP_IDX_MODE, 32'h8, OK);
    acc(1'b1, `CSP_IDX_CTRL, 32'h88, OK);
    u_csp_host_model.period(1'b1, 32'h0F000000);
    chk({drv.en, drv.lag_fault, drv.frc}, {16'h0, 2'b10, 16'h1388});
    acc(1'b1, `CSP_IDX_VEL_OFS, 32'h100, OK);
    acc(1'b1, `CSP_IDX_FRC_OFS, 32'h5, OK);
    acc(1'b1, `CSP_IDX_LAG_WIN, 32'h100, OK);
    u_csp_host_model.period(1'b1, 32'h100);
    chk({drv.en, drv.lag_fault, drv.frc}, {16'h0, 2'b10, 16'h0016});
    acc(1'b0, `CSP_IDX_LAG_ACT, 32'h0, {2'b10, 32'h100});
    acc(1'b0, `CSP_IDX_FRC_ACT, 32'h0, {2'b10, 32'h0123});
    acc(1'b1, `CSP_IDX_LAG_WIN, 32'hFF, OK);
    u_csp_host_model.period(1'b1, 32'h100);
    acc(1'b0, `CSP_IDX_STAT, 32'h0, {2'b10, 32'h2004});
    acc(1'b1, `CSP_IDX_CTRL, 32'h88, OK);
    acc(1'b0, `CSP_IDX_STAT, 32'h0, {2'b10, 32'h0004});
    acc(1'b1, `CSP_IDX_LAG_WIN, 32'h0, OK);
    u_csp_host_model.period(1'b1, 32'h0);
    acc(1'b0, `CSP_IDX_STAT, 32'h0, {2'b10, 32'h2004});
    chk({drv.en, drv.lag_fault}, 34'h3);
    // negative lag under a wide window: only its magnitude may be compared
    acc(1'b1, `CSP_IDX_CTRL, 32'h88, OK);
    acc(1'b1, `CSP_IDX_LAG_WIN, 32'h08000000, OK);
    acc(1'b1, `CSP_IDX_POS_OFS, 32'h10, OK);
    enc_position = 32'h01000000;
    u_csp_host_model.period(1'b1, 32'h0);
    chk({drv.en, drv.lag_fault, drv.frc}, {16'h0, 2'b10, 16'hEC78});
    acc(1'b0, `CSP_IDX_POS_ACT, 32'h0, {2'b10, 32'h01000000});
    acc(1'b0, `CSP_IDX_VEL_ACT, 32'h0, {2'b10, 32'h01000000});
    acc(1'b0, `CSP_IDX_LAG_ACT, 32'h0, {2'b10, 32'hFF000010});
    acc(1'b0, `CSP_IDX_STAT, 32'h0, {2'b10, 32'h0004});
  endtask
  task automatic summarize;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #10;
    srst = 1'b0;
    t_reset;
    t_window;
    t_fifo;
    t_loop;
    summarize;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    summarize;
  end
endmodule
